/* File: design/wmc_config_decode.sv */
`timescale 1ns/10ps
module wmc_config_decode #(
    parameter int          DW        = 16,
    parameter logic [15:0] PROG_WORDS = 16'h0800,
    parameter logic [15:0] SAF_WORDS  = 16'h0080
) (
    // Clock and reset
    input  wire logic                 clk,
    input  wire logic                 rst,
    // Nonvolatile words and erase
    input  wire logic [13:0]          nvWdWord,
    input  wire logic [13:0]          nvMemWord,
    input  wire logic                 bulkErase,
    // Core and pin state
    input  wire logic                 lvpActivePin,
    input  wire logic                 sleep,
    input  wire logic                 resetPinEnable,
    // Register port
    input  wire logic [3:0]           busAddr,
    input  wire logic [DW-1:0]        busWrData,
    input  wire logic                 busWr,
    input  wire logic                 busRd,
    output logic      [DW-1:0]        busRdData,
    // Self-write check
    input  wire logic                 nvmWrReq,
    input  wire logic [15:0]          nvmWrAddr,
    output logic                      nvmWrAllow,
    // Decoded settings
    output wmc_pkg::wmc_wd_cfg_t      wdCfg,
    output wmc_pkg::wmc_part_t        partCfg
);

    // ********
    // Declarations
    // ********
    logic                 loadPending;
    logic                 initPending;
    logic [13:0]          wdImage;
    logic [13:0]          wdSnap;
    logic [13:0]          memImage;
    logic [13:0]          memSnap;
    logic                 wdWrEn;
    logic                 memWrEn;
    logic [13:0]          next_wdWord;
    logic [13:0]          next_memWord;
    logic                 lvpMeta;
    logic                 lvpS2;
    logic                 lvpS3;
    logic                 lvpActive;
    logic                 ctrlSwEn;
    logic [2:0]           ctrlClk;
    logic [2:0]           ctrlWin;
    logic [4:0]           ctrlPer;
    logic [2:0]           clkCode;
    logic [2:0]           winCfg;
    logic                 winSw;
    logic [2:0]           winPor;
    logic [4:0]           perCfg;
    logic                 perSw;
    logic [4:0]           perPor;
    logic [15:0]          bootWords;
    logic                 bootEn;
    logic                 storage_area_enable_n;
    logic                 inBoot;
    logic                 inSaf;
    logic                 inCfg;
    logic                 inApp;
    wmc_pkg::wmc_wd_cfg_t next_wdCfg;
    wmc_pkg::wmc_part_t   next_partCfg;

    // ********
    // Capture sequencing after reset release
    // ********
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            loadPending <= 1'b1;
            initPending <= 1'b0;
        end else begin
            loadPending <= 1'b0;
            initPending <= loadPending;
        end
    end

    // ********
    // Stored words
    // ********
    wmc_cfg_cell #(
        .W (wmc_pkg::CW)
    ) u_wd_cell (
        .clk      (clk),
        .rst      (rst),
        .load     (loadPending),
        .erase    (bulkErase),
        .wrEn     (wdWrEn),
        .nvWord   (nvWdWord | wmc_pkg::WD_UNIMP_MASK),
        .wrData   (next_wdWord),
        .image    (wdImage),
        .snapshot (wdSnap)
    );

    wmc_cfg_cell #(
        .W (wmc_pkg::CW)
    ) u_mem_cell (
        .clk      (clk),
        .rst      (rst),
        .load     (loadPending),
        .erase    (bulkErase),
        .wrEn     (memWrEn),
        .nvWord   (nvMemWord | wmc_pkg::MEM_UNIMP_MASK),
        .wrData   (next_memWord),
        .image    (memImage),
        .snapshot (memSnap)
    );

    // ********
    // Programming interface synchroniser
    // ********
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            lvpMeta <= 1'b0;
            lvpS2   <= 1'b0;
            lvpS3   <= 1'b0;
        end else begin
            lvpMeta <= lvpActivePin;
            lvpS2   <= lvpMeta;
            lvpS3   <= lvpS2;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            lvpActive <= 1'b0;
        end else if (lvpS2 == lvpS3) begin
            lvpActive <= lvpS3;
        end
    end

    // ********
    // Configuration word writes
    // ********
    assign wdWrEn  = busWr && (busAddr == wmc_pkg::ADDR_WD_WORD)
                     && !next_partCfg.cfgBlock;
    assign memWrEn = busWr && (busAddr == wmc_pkg::ADDR_MEM_WORD)
                     && !next_partCfg.cfgBlock;

    always_comb begin
        next_wdWord = busWrData[13:0] | wmc_pkg::WD_UNIMP_MASK;
    end

    always_comb begin
        next_memWord = (busWrData[13:0] & ~wmc_pkg::MEM_STICKY_MASK)
                     | (busWrData[13:0] & memImage & wmc_pkg::MEM_STICKY_MASK);
        if (lvpActive && memImage[wmc_pkg::MEM_LVP_BIT]) begin
            next_memWord[wmc_pkg::MEM_LVP_BIT] = 1'b1;
        end
        if (!memImage[wmc_pkg::MEM_BOOT_BLOCK_ENABLE_N_BIT]) begin
            next_memWord[wmc_pkg::MEM_BBSZ_LSB +: 3] =
                memImage[wmc_pkg::MEM_BBSZ_LSB +: 3];
        end
        next_memWord = next_memWord | wmc_pkg::MEM_UNIMP_MASK;
    end

    // ********
    // Watchdog control register
    // ********
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            ctrlSwEn <= wmc_pkg::CTRL_SWEN_RST;
            ctrlClk  <= wmc_pkg::CTRL_CLK_RST;
        end else if (busWr && busAddr == wmc_pkg::ADDR_WD_CTRL) begin
            ctrlSwEn <= busWrData[wmc_pkg::CTRL_SWEN_BIT];
            ctrlClk  <= busWrData[wmc_pkg::CTRL_CLK_LSB +: 3];
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            ctrlWin <= wmc_pkg::WIN_OPEN;
        end else if (initPending) begin
            ctrlWin <= winPor;
        end else if (busWr && busAddr == wmc_pkg::ADDR_WD_CTRL && winSw) begin
            ctrlWin <= busWrData[wmc_pkg::CTRL_WIN_LSB +: 3];
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            ctrlPer <= wmc_pkg::PER_ERASED_POR;
        end else if (initPending) begin
            ctrlPer <= perPor;
        end else if (busWr && busAddr == wmc_pkg::ADDR_WD_CTRL && perSw) begin
            ctrlPer <= busWrData[wmc_pkg::CTRL_PER_LSB +: 5];
        end
    end

    // ********
    // Watchdog decode
    // ********
    always_comb begin
        winCfg = wdSnap[wmc_pkg::WD_WIN_LSB +: 3];
        winSw  = (winCfg == wmc_pkg::WIN_OPEN) || (winCfg == wmc_pkg::WIN_OPEN_ALT);
        winPor = winSw ? wmc_pkg::WIN_OPEN : winCfg;
        perCfg = wdSnap[wmc_pkg::WD_PER_LSB +: 5];
        perSw  = (perCfg == wmc_pkg::PER_ERASED);
        perPor = perSw ? wmc_pkg::PER_ERASED_POR : perCfg;
        clkCode = wdSnap[wmc_pkg::WD_CLK_LSB +: 3];
        if (clkCode == wmc_pkg::CLK_SOFT_CODE) begin
            clkCode = ctrlClk;
        end
    end

    always_comb begin
        next_wdCfg = '0;
        if (clkCode == wmc_pkg::CLK_LOW_CODE) begin
            next_wdCfg.clkSrc = wmc_pkg::WMC_CLK_LOW;
        end else if (clkCode == wmc_pkg::CLK_MID_CODE) begin
            next_wdCfg.clkSrc = wmc_pkg::WMC_CLK_MID;
        end else begin
            next_wdCfg.clkSrc = wmc_pkg::WMC_CLK_RSVD;
        end
        next_wdCfg.windowValue  = ctrlWin;
        next_wdCfg.windowSwCtrl = winSw;
        next_wdCfg.keyedAccess  = !winSw;
        if (ctrlWin >= wmc_pkg::WIN_OPEN_ALT) begin
            next_wdCfg.closedEighths = 3'h0;
        end else begin
            next_wdCfg.closedEighths = wmc_pkg::WIN_OPEN - ctrlWin;
        end
        next_wdCfg.periodValue  = ctrlPer;
        next_wdCfg.periodSwCtrl = perSw;
        if (ctrlPer <= wmc_pkg::PER_MAX) begin
            next_wdCfg.divExp = ctrlPer + wmc_pkg::PER_BASE_EXP;
        end else begin
            next_wdCfg.divExp = wmc_pkg::PER_BASE_EXP;
        end
        unique case (wdSnap[wmc_pkg::WD_MODE_LSB +: 2])
            wmc_pkg::MODE_ALWAYS: next_wdCfg.running = 1'b1;
            wmc_pkg::MODE_AWAKE:  next_wdCfg.running = !sleep;
            wmc_pkg::MODE_SOFT:   next_wdCfg.running = ctrlSwEn;
            wmc_pkg::MODE_OFF:    next_wdCfg.running = 1'b0;
        endcase
    end

    // ********
    // Partition decode
    // ********
    always_comb begin
        bootEn = !memSnap[wmc_pkg::MEM_BOOT_BLOCK_ENABLE_N_BIT];
        storage_area_enable_n  = !memSnap[wmc_pkg::MEM_STORAGE_AREA_ENABLE_N_BIT];
        if (!bootEn) begin
            bootWords = 16'h0000;
        end else if (memSnap[wmc_pkg::MEM_BBSZ_LSB +: 3] == wmc_pkg::BB_SMALL_CODE) begin
            bootWords = wmc_pkg::BB_SMALL_WORDS;
        end else begin
            bootWords = wmc_pkg::BB_LARGE_WORDS;
        end
        if (bootWords > (PROG_WORDS >> 1)) begin
            bootWords = PROG_WORDS >> 1;
        end
    end

    always_comb begin
        next_partCfg = '0;
        next_partCfg.lowVoltProg   = memSnap[wmc_pkg::MEM_LVP_BIT];
        next_partCfg.resetIsMaster = memSnap[wmc_pkg::MEM_LVP_BIT] || resetPinEnable;
        next_partCfg.safEnabled    = storage_area_enable_n;
        next_partCfg.bootEnabled   = bootEn;
        next_partCfg.bootSize      = bootWords;
        next_partCfg.bootLast      = bootEn ? bootWords - 16'h0001 : 16'h0000;
        next_partCfg.safBlock  = storage_area_enable_n && !memSnap[wmc_pkg::MEM_SAFWP_BIT];
        next_partCfg.cfgBlock  = !memSnap[wmc_pkg::MEM_CFGWP_BIT];
        next_partCfg.bootBlock = bootEn && !memSnap[wmc_pkg::MEM_BOOTWP_BIT];
        next_partCfg.appBlock  = !memSnap[wmc_pkg::MEM_APPWP_BIT];
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            wdCfg   <= '0;
            partCfg <= '0;
        end else begin
            wdCfg   <= next_wdCfg;
            partCfg <= next_partCfg;
        end
    end

    // ********
    // Self-write region check
    // ********
    always_comb begin
        inCfg  = nvmWrAddr[15];
        inBoot = !inCfg && partCfg.bootEnabled && (nvmWrAddr < partCfg.bootSize);
        inSaf  = !inCfg && partCfg.safEnabled && (nvmWrAddr < PROG_WORDS)
                 && (nvmWrAddr >= PROG_WORDS - SAF_WORDS);
        inApp  = !inCfg && !inBoot && !inSaf && (nvmWrAddr < PROG_WORDS);
    end

    always_comb begin
        nvmWrAllow = 1'b0;
        if (nvmWrReq) begin
            if (inCfg) begin
                nvmWrAllow = !partCfg.cfgBlock;
            end else if (inBoot) begin
                nvmWrAllow = !partCfg.bootBlock;
            end else if (inSaf) begin
                nvmWrAllow = !partCfg.safBlock;
            end else if (inApp) begin
                nvmWrAllow = !partCfg.appBlock;
            end
        end
    end

    // ********
    // Register reads
    // ********
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            busRdData <= '0;
        end else begin
            busRdData <= '0;
            if (busRd) begin
                unique case (busAddr)
                    wmc_pkg::ADDR_WD_WORD: begin
                        busRdData[13:0] <= wdImage | wmc_pkg::WD_UNIMP_MASK;
                    end
                    wmc_pkg::ADDR_MEM_WORD: begin
                        busRdData[13:0] <= memImage | wmc_pkg::MEM_UNIMP_MASK;
                    end
                    wmc_pkg::ADDR_WD_CTRL: begin
                        busRdData[wmc_pkg::CTRL_SWEN_BIT]     <= ctrlSwEn;
                        busRdData[wmc_pkg::CTRL_CLK_LSB +: 3] <= ctrlClk;
                        busRdData[wmc_pkg::CTRL_WIN_LSB +: 3] <= ctrlWin;
                        busRdData[wmc_pkg::CTRL_PER_LSB +: 5] <= ctrlPer;
                    end
                    wmc_pkg::ADDR_STATUS: begin
                        busRdData[0] <= wdCfg.running;
                        busRdData[1] <= lvpActive;
                        busRdData[2] <= partCfg.cfgBlock;
                        busRdData[3] <= wdCfg.keyedAccess;
                        busRdData[4] <= wdCfg.windowSwCtrl;
                        busRdData[5] <= wdCfg.periodSwCtrl;
                        busRdData[6] <= partCfg.bootEnabled;
                        busRdData[7] <= partCfg.safEnabled;
                    end
                    default: begin
                        busRdData <= '0;
                    end
                endcase
            end
        end
    end

endmodule

/* File: design/wmc_pkg.sv */
package wmc_pkg;

    // ********
    // Word layout
    // ********
    localparam int          CW            = 14;
    localparam logic [13:0] ERASED_WORD   = 14'h3fff;
    localparam logic [13:0] WD_UNIMP_MASK = 14'h0080;
    localparam logic [13:0] MEM_UNIMP_MASK = 14'h1460;
    localparam logic [13:0] MEM_STICKY_MASK = 14'h0b98;

    localparam int WD_CLK_LSB  = 11;
    localparam int WD_WIN_LSB  = 8;
    localparam int WD_MODE_LSB = 5;
    localparam int WD_PER_LSB  = 0;

    localparam int MEM_LVP_BIT    = 13;
    localparam int MEM_SAFWP_BIT  = 11;
    localparam int MEM_CFGWP_BIT  = 9;
    localparam int MEM_BOOTWP_BIT = 8;
    localparam int MEM_APPWP_BIT  = 7;
    localparam int MEM_STORAGE_AREA_ENABLE_N_BIT  = 4;
    localparam int MEM_BOOT_BLOCK_ENABLE_N_BIT   = 3;
    localparam int MEM_BBSZ_LSB   = 0;

    // ********
    // Field codes
    // ********
    localparam logic [2:0] CLK_MID_CODE  = 3'h0;
    localparam logic [2:0] CLK_LOW_CODE  = 3'h1;
    localparam logic [2:0] CLK_SOFT_CODE = 3'h7;
    localparam logic [2:0] WIN_OPEN      = 3'h7;
    localparam logic [2:0] WIN_OPEN_ALT  = 3'h6;
    localparam logic [1:0] MODE_ALWAYS   = 2'h3;
    localparam logic [1:0] MODE_AWAKE    = 2'h2;
    localparam logic [1:0] MODE_SOFT     = 2'h1;
    localparam logic [1:0] MODE_OFF      = 2'h0;
    localparam logic [4:0] PER_ERASED    = 5'h1f;
    localparam logic [4:0] PER_ERASED_POR = 5'h0b;
    localparam logic [4:0] PER_MAX       = 5'h12;
    localparam logic [4:0] PER_BASE_EXP  = 5'h05;
    localparam logic [2:0] BB_SMALL_CODE = 3'h7;
    localparam logic [15:0] BB_SMALL_WORDS = 16'h0200;
    localparam logic [15:0] BB_LARGE_WORDS = 16'h0400;

    // ********
    // Register map
    // ********
    localparam logic [3:0] ADDR_WD_WORD  = 4'h0;
    localparam logic [3:0] ADDR_MEM_WORD = 4'h1;
    localparam logic [3:0] ADDR_WD_CTRL  = 4'h2;
    localparam logic [3:0] ADDR_STATUS   = 4'h3;

    localparam int CTRL_SWEN_BIT = 0;
    localparam int CTRL_CLK_LSB  = 1;
    localparam int CTRL_WIN_LSB  = 4;
    localparam int CTRL_PER_LSB  = 7;
    localparam logic       CTRL_SWEN_RST = 1'b0;
    localparam logic [2:0] CTRL_CLK_RST  = 3'h0;

    // ********
    // Types
    // ********
    typedef enum logic [1:0] {
        WMC_CLK_MID,
        WMC_CLK_LOW,
        WMC_CLK_RSVD
    } wmc_clk_src_t;

    typedef struct packed {
        wmc_clk_src_t clkSrc;
        logic [2:0]   windowValue;
        logic [2:0]   closedEighths;
        logic         windowSwCtrl;
        logic         keyedAccess;
        logic [4:0]   periodValue;
        logic [4:0]   divExp;
        logic         periodSwCtrl;
        logic         running;
    } wmc_wd_cfg_t;

    typedef struct packed {
        logic        lowVoltProg;
        logic        resetIsMaster;
        logic        safEnabled;
        logic        bootEnabled;
        logic [15:0] bootSize;
        logic [15:0] bootLast;
        logic        safBlock;
        logic        cfgBlock;
        logic        bootBlock;
        logic        appBlock;
    } wmc_part_t;

endpackage

/* File: design/wmc_cfg_cell.sv */
`timescale 1ns/10ps
module wmc_cfg_cell #(
    parameter int W = 14
) (
    // Clock and reset
    input  wire logic         clk,
    input  wire logic         rst,
    // Capture, erase and update
    input  wire logic         load,
    input  wire logic         erase,
    input  wire logic         wrEn,
    input  wire logic [W-1:0] nvWord,
    input  wire logic [W-1:0] wrData,
    // Stored words
    output logic      [W-1:0] image,
    output logic      [W-1:0] snapshot
);

    // ********
    // Stored image, changed by writes and erase
    // ********
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            image <= '1;
        end else if (load || erase) begin
            image <= erase ? '1 : nvWord;
        end else if (wrEn) begin
            image <= wrData;
        end
    end

    // ********
    // Snapshot, held until the next reset
    // ********
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            snapshot <= '1;
        end else if (load) begin
            snapshot <= nvWord;
        end
    end

endmodule

/* File: sim/wmc_config_decode_sva.sv */
`timescale 1ns/10ps
module wmc_config_decode_sva #(
    parameter logic [15:0] PROG_WORDS = 16'h0800,
    parameter logic [15:0] SAF_WORDS  = 16'h0080
) (
    // Clock and reset
    input  wire logic                 clk,
    input  wire logic                 rst,
    // Watched ports
    input  wire logic                 busRd,
    input  wire logic [15:0]          busRdData,
    input  wire logic                 nvmWrReq,
    input  wire logic [15:0]          nvmWrAddr,
    input  wire logic                 nvmWrAllow,
    input  wire wmc_pkg::wmc_wd_cfg_t wdCfg,
    input  wire wmc_pkg::wmc_part_t   partCfg
);
    // ********
    // Cycles since reset release
    // ********
    logic [2:0] age;
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            age <= 3'h0;
        end else if (age != 3'h7) begin
            age <= age + 3'h1;
        end
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    // ********
    // Checks
    // ********
    a_allow_needs_req: assert property (nvmWrAllow |-> nvmWrReq)
        else $error("allow without request");
    a_cfg_refused: assert property (nvmWrReq && nvmWrAddr[15] && partCfg.cfgBlock |-> !nvmWrAllow)
        else $error("config self-write allowed");
    a_boot_refused: assert property (nvmWrReq && partCfg.bootBlock && nvmWrAddr < partCfg.bootSize
        |-> !nvmWrAllow) else $error("boot self-write allowed");
    a_app_refused: assert property (nvmWrReq && partCfg.appBlock && !nvmWrAddr[15]
        && nvmWrAddr >= partCfg.bootSize && nvmWrAddr < PROG_WORDS - SAF_WORDS
        |-> !nvmWrAllow) else $error("app self-write allowed");
    a_saf_refused: assert property (nvmWrReq && partCfg.safBlock && nvmWrAddr < PROG_WORDS
        && nvmWrAddr >= PROG_WORDS - SAF_WORDS |-> !nvmWrAllow) else $error("saf write");
    a_boot_size: assert property (age == 3'h7 |-> (partCfg.bootEnabled ? partCfg.bootSize != 0
        && partCfg.bootLast == partCfg.bootSize - 16'h0001 : partCfg.bootSize == 16'h0000))
        else $error("boot size wrong");
    a_boot_cap: assert property (partCfg.bootSize <= (PROG_WORDS >> 1))
        else $error("boot block above half");
    a_decode_held: assert property (age == 3'h7 |-> $stable(partCfg)
        && $stable(wdCfg.keyedAccess) && $stable(wdCfg.windowSwCtrl)
        && $stable(wdCfg.periodSwCtrl)) else $error("decode changed");
    a_lvp_master: assert property (age == 3'h7 && partCfg.lowVoltProg |-> partCfg.resetIsMaster)
        else $error("reset pin not master");
    a_window_keyed: assert property (age == 3'h7 && wdCfg.keyedAccess |-> !wdCfg.windowSwCtrl
        && wdCfg.closedEighths == 3'h7 - wdCfg.windowValue) else $error("window");
    a_div_range: assert property (age == 3'h7 |-> wdCfg.divExp >= 5'h05 && wdCfg.divExp <= 5'h17)
        else $error("divider out of range");
    c_refused: cover property (nvmWrReq && !nvmWrAllow);
    c_boot_on: cover property (partCfg.bootEnabled);
    c_read: cover property ($past(busRd) && busRdData != 16'h0000);
endmodule

/* File: sim/wmc_nvm_writer.sv */
`timescale 1ns/10ps
module wmc_nvm_writer (
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        rst,
    // Bench command
    input  wire logic        go,
    input  wire logic [15:0] goAddr,
    output logic             granted,
    // Self-write check
    output logic             nvmWrReq,
    output logic [15:0]      nvmWrAddr,
    input  wire logic        nvmWrAllow
);
    // ********
    // One self-write request, dropped and address inverted once answered
    // ********
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            nvmWrReq <= 1'b0;
            nvmWrAddr <= 16'hffff;
            granted <= 1'b0;
        end else if (go) begin
            nvmWrReq <= 1'b1;
            nvmWrAddr <= goAddr;
        end else if (nvmWrReq) begin
            granted <= nvmWrAllow;
            nvmWrReq <= 1'b0;
            nvmWrAddr <= ~nvmWrAddr;
        end
    end
endmodule

/* File: sim/tb_wmc_config_decode.sv */
`timescale 1ns/10ps
module tb_wmc_config_decode;
    localparam logic [15:0] PW = 16'h0600;
    localparam logic [15:0] SW = 16'h0080;
    logic                 clk = 1'b0, rst = 1'b1, bulkErase = 1'b0, lvpActivePin = 1'b0;
    logic                 sleep = 1'b0, rstPinEn = 1'b0, busWr = 1'b0, busRd = 1'b0, go = 1'b0;
    logic                 granted, nvmWrReq, nvmWrAllow;
    logic [13:0]          nvWdWord = 14'h3fff, nvMemWord = 14'h3fff;
    logic [3:0]           busAddr = 4'h0;
    logic [15:0]          busWrData = 16'h0, goAddr = 16'h0, busRdData, nvmWrAddr;
    wmc_pkg::wmc_wd_cfg_t wdCfg;
    wmc_pkg::wmc_part_t   partCfg;
    int                   fail_count = 0, checks_done = 0;
    logic [15:0]          adr [6] = '{16'h0100, 16'h0250, 16'h0400, 16'h05c0, 16'h0700, 16'h8007};
    logic [13:0]          mt [4] = '{14'h3fff, 14'h1467, 14'h3ff0, 14'h36ff};
    logic [4:0]           pt [8] = '{5'h00, 5'h01, 5'h12, 5'h13, 5'h1e, 5'h0b, 5'h0a, 5'h1f};
    always #20 clk = ~clk;
    wmc_config_decode #(.PROG_WORDS(PW), .SAF_WORDS(SW)) u_wmc_config_decode (
        .clk(clk), .rst(rst), .nvWdWord(nvWdWord), .nvMemWord(nvMemWord), .bulkErase(bulkErase),
        .lvpActivePin(lvpActivePin), .sleep(sleep), .resetPinEnable(rstPinEn),
        .busAddr(busAddr), .busWrData(busWrData), .busWr(busWr), .busRd(busRd),
        .busRdData(busRdData), .nvmWrReq(nvmWrReq), .nvmWrAddr(nvmWrAddr),
        .nvmWrAllow(nvmWrAllow), .wdCfg(wdCfg), .partCfg(partCfg));
    wmc_nvm_writer u_wmc_nvm_writer (.clk(clk), .rst(rst), .go(go), .goAddr(goAddr),
        .granted(granted), .nvmWrReq(nvmWrReq), .nvmWrAddr(nvmWrAddr), .nvmWrAllow(nvmWrAllow));
    // ********
    // Expected values
    // ********
    function automatic wmc_pkg::wmc_wd_cfg_t exp_wd(input logic [13:0] w, input logic sl,
        input logic [15:0] k);
        logic [2:0] cc;
        logic [4:0] pv;
        exp_wd = '0;
        cc = (w[13:11] == 3'h7) ? k[3:1] : w[13:11];
        exp_wd.clkSrc = (cc == 3'h0) ? wmc_pkg::WMC_CLK_MID
            : (cc == 3'h1) ? wmc_pkg::WMC_CLK_LOW : wmc_pkg::WMC_CLK_RSVD;
        exp_wd.windowSwCtrl = w[10:8] >= 3'h6;
        exp_wd.keyedAccess = w[10:8] <= 3'h5;
        exp_wd.windowValue = !exp_wd.windowSwCtrl ? w[10:8] : (k != 16'h0) ? k[6:4] : 3'h7;
        exp_wd.closedEighths = (exp_wd.windowValue <= 3'h5) ? 3'h7 - exp_wd.windowValue : 3'h0;
        exp_wd.periodSwCtrl = w[4:0] == 5'h1f;
        pv = !exp_wd.periodSwCtrl ? w[4:0] : (k != 16'h0) ? k[11:7] : 5'h0b;
        exp_wd.periodValue = pv;
        exp_wd.divExp = (pv <= 5'h12) ? pv + 5'h05 : 5'h05;
        exp_wd.running = w[6] ? (w[5] | ~sl) : (w[5] & k[0]);
    endfunction
    function automatic wmc_pkg::wmc_part_t exp_part(input logic [13:0] m, input logic rp);
        exp_part = '0;
        exp_part.lowVoltProg = m[13];
        exp_part.resetIsMaster = m[13] | rp;
        exp_part.safEnabled = ~m[4];
        exp_part.bootEnabled = ~m[3];
        if (~m[3]) begin
            exp_part.bootSize = (m[2:0] == 3'h7) ? 16'h0200 : 16'h0400;
            exp_part.bootSize = (exp_part.bootSize > PW / 2) ? PW / 2 : exp_part.bootSize;
            exp_part.bootLast = exp_part.bootSize - 16'h0001;
        end
        exp_part.safBlock = ~m[4] & ~m[11];
        exp_part.cfgBlock = ~m[9];
        exp_part.bootBlock = ~m[3] & ~m[8];
        exp_part.appBlock = ~m[7];
    endfunction
    function automatic logic exp_allow(input wmc_pkg::wmc_part_t p, input logic [15:0] a);
        if (a[15]) return ~p.cfgBlock;
        if (p.bootEnabled && a < p.bootSize) return ~p.bootBlock;
        if (p.safEnabled && a >= PW - SW && a < PW) return ~p.safBlock;
        return (a < PW) & ~p.appBlock;
    endfunction
    // ********
    // Compares and bus cycles
    // ********
    task automatic note(input logic ok, input string m);
        checks_done++;
        if (ok !== 1'b1) begin
            fail_count++;
            $display("mismatch at %0t: %s", $time, m);
        end
    endtask
    task automatic chk_val(input logic [15:0] g, e, input string m);
        note(g === e, m);
    endtask
    task automatic chk_wd(input wmc_pkg::wmc_wd_cfg_t g, e);
        note(g === e, "watchdog decode");
    endtask
    task automatic chk_part(input wmc_pkg::wmc_part_t g, e);
        note(g === e, "partition decode");
    endtask
    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge clk);
        busAddr <= a;
        busWrData <= d;
        busWr <= 1'b1;
        @(posedge clk);
        busWr <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a, input logic [15:0] e, input string m);
        @(posedge clk);
        busAddr <= a;
        busRd <= 1'b1;
        @(posedge clk);
        busRd <= 1'b0;
        #1 chk_val(busRdData, e, m);
    endtask
    task automatic probe(input logic [15:0] a, input logic e);
        @(posedge clk);
        go <= 1'b1;
        goAddr <= a;
        @(posedge clk);
        go <= 1'b0;
        @(posedge clk);
        #1 chk_val(16'(granted), 16'(e), "self-write answer");
    endtask
    task automatic rst_dut(input logic [13:0] w, m, input logic sl, rp);
        @(posedge clk);
        rst <= 1'b1;
        nvWdWord <= w;
        nvMemWord <= m;
        sleep <= sl;
        rstPinEn <= rp;
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        repeat (4) @(posedge clk);
        #1;
    endtask
    task automatic stop_test();
        $display("checks %0d mismatches %0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    // ********
    // Tests
    // ********
    initial begin
        logic [13:0] w;
        logic [13:0] m;
        logic        sl;
        logic        rp;
        for (int k = 0; k < 12; k++) begin
            w = (k < 8) ? {k[2:0], k[2:0], 1'b1, k[1:0], pt[k % 8]} : 14'h3fff;
            m = (k < 8) ? 14'h3fff : mt[k % 4];
            sl = k[2] & (k < 8);
            rp = (k == 11);
            rst_dut(w, m, sl, rp);
            chk_wd(wdCfg, exp_wd(w, sl, 16'h0));
            chk_part(partCfg, exp_part(m, rp));
            for (int j = 0; j < 6; j++) begin
                probe(adr[j], exp_allow(exp_part(m, rp), adr[j]));
            end
            wr(4'h2, 16'h0223);
            repeat (3) @(posedge clk);
            #1 chk_wd(wdCfg, exp_wd(w, sl, 16'h0223));
            wr(4'h1, 16'h3fff);
            rd(4'h1, m[9] ? (m | 14'h3460 | {11'h0, {3{m[3]}}}) : m, "memory word");
            $display("test config %0d done", k);
        end
        rst_dut(14'h3fff, 14'h3fff, 1'b0, 1'b0);
        rd(4'h3, 16'h0031, "status");
        rd(4'h9, 16'h0000, "unmapped");
        wr(4'h0, 16'h0000);
        wr(4'h1, 16'h0000);
        rd(4'h0, 16'h0080, "watchdog word");
        rd(4'h1, 16'h1460, "memory word");
        chk_part(partCfg, exp_part(14'h3fff, 1'b0));
        @(posedge clk);
        bulkErase <= 1'b1;
        @(posedge clk);
        bulkErase <= 1'b0;
        rd(4'h1, 16'h3fff, "after erase");
        @(posedge clk) lvpActivePin <= 1'b1;
        repeat (5) @(posedge clk);
        wr(4'h1, 16'h1fff);
        rd(4'h1, 16'h3fff, "low-volt bit held");
        $display("test registers done");
        stop_test();
    end
    initial begin
        #400000;
        fail_count++;
        $display("mismatch at %0t: watchdog expired", $time);
        stop_test();
    end
endmodule
bind wmc_config_decode wmc_config_decode_sva #(.PROG_WORDS(PROG_WORDS), .SAF_WORDS(SAF_WORDS))
    u_wmc_config_decode_sva (.clk(clk), .rst(rst), .busRd(busRd), .busRdData(busRdData),
    .nvmWrReq(nvmWrReq), .nvmWrAddr(nvmWrAddr), .nvmWrAllow(nvmWrAllow), .wdCfg(wdCfg),
    .partCfg(partCfg));
